// ### opstat_defines.svh
// Constants for the operation status reporting block.
`ifndef OPSTAT_DEFINES_SVH
`define OPSTAT_DEFINES_SVH
`define OPSTAT_REG_W        16
`define OPSTAT_MEAS_BIT     4
`define OPSTAT_SWEEP_BIT    3
`define OPSTAT_CORR_BIT     0
`define OPSTAT_LIVE_MASK    16'h0019
`define OPSTAT_RESET_VALUE  16'h0000
`define OPSTAT_SUMMARY_BIT  7
`define OPSTAT_STB_W        8
`endif

// ### opstat_pkg.sv
// Types for the operation status reporting block.
`include "opstat_defines.svh"
package opstat_pkg;
   typedef logic [`OPSTAT_REG_W-1:0] opstat_word_type;
   typedef enum logic [2:0] {
      OPSTAT_SEL_EVENT = 3'h1,
      OPSTAT_SEL_COND  = 3'h2,
      OPSTAT_SEL_MASK  = 3'h4
   } opstat_sel_type;
endpackage

// ### opstat_core.sv
// Operation status registers: live condition, latched events and enable mask.
// What this block does
// - Event query returns events, then clears them.
// - Event bits 4, 3, 0 latch completions.
// - Condition bits 4, 3, 0 show live activity.
// - Bits 15-5, 2, 1 always read zero.
// - Condition query leaves condition register untouched.
// - Enable command stores mask gating summary.
// - Enable query returns mask without side effects.
// - Mask value is binary-weighted; 16 means bit 4.
// - Reported values are binary-weighted sums of bits.
// - Summary appears in status byte bit 7.
`timescale 1ns/1ps
`include "opstat_defines.svh"
module opstat_core (
   input  wire logic                     ref_clk,
   input  wire logic                     srst,
   input  wire logic                     meas_active,
   input  wire logic                     sweep_active,
   input  wire logic                     corr_active,
   input  wire logic                     meas_done,
   input  wire logic                     sweep_done,
   input  wire logic                     corr_done,
   input  wire logic                     query_event,
   input  wire logic                     query_cond,
   input  wire logic                     query_mask,
   input  wire logic                     mask_write,
   input  wire opstat_pkg::opstat_word_type mask_value,
   output logic                          resp_valid,
   output opstat_pkg::opstat_word_type   resp_value,
   output logic                          summary_bit,
   output logic [`OPSTAT_STB_W-1:0]      status_byte_part
);
   import opstat_pkg::*;

   // Two stored registers, plus two combinational vectors built from the activity and completion pins.
   opstat_word_type operation_event_flags_reg;
   opstat_word_type operation_event_mask_reg;
   opstat_word_type operation_condition_flags;
   opstat_word_type done_vec;

   // ====================================================================
   // Condition and completion vectors
   // Live activity is combinational so the condition query always sees the present state.
   // Limitation: the activity levels must already be synchronous to ref_clk.
   always_comb begin
      operation_condition_flags = `OPSTAT_RESET_VALUE;
      operation_condition_flags[`OPSTAT_MEAS_BIT]  = meas_active;
      operation_condition_flags[`OPSTAT_SWEEP_BIT] = sweep_active;
      operation_condition_flags[`OPSTAT_CORR_BIT]  = corr_active;
      done_vec = `OPSTAT_RESET_VALUE;
      done_vec[`OPSTAT_MEAS_BIT]  = meas_done;
      done_vec[`OPSTAT_SWEEP_BIT] = sweep_done;
      done_vec[`OPSTAT_CORR_BIT]  = corr_done;
   end

   // ====================================================================
   // Event latch
   // A completion arriving in the read cycle survives the clear, so no event is lost.
   // Apart from reset, a read is the only way a bit can go back to zero.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         operation_event_flags_reg <= `OPSTAT_RESET_VALUE;
      end else if (query_event) begin
         operation_event_flags_reg <= done_vec;
      end else begin
         operation_event_flags_reg <= operation_event_flags_reg | done_vec;
      end
   end

   // ====================================================================
   // Enable mask
   // Unused bits are dropped at the write so they can never read back as one.
   // The summary follows a new mask from the cycle after the write.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         operation_event_mask_reg <= `OPSTAT_RESET_VALUE;
      end else if (mask_write) begin
         operation_event_mask_reg <= mask_value & `OPSTAT_LIVE_MASK;
      end
   end

   // ====================================================================
   // Query response
   // Values are plain binary, which is the weighted decimal sum the formatter prints.
   // Queries in one cycle get one answer: events first, then condition, then mask.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         resp_valid <= 1'h0;
         resp_value <= `OPSTAT_RESET_VALUE;
      end else begin
         resp_valid <= query_event | query_cond | query_mask;
         if (query_event) begin
            resp_value <= operation_event_flags_reg;
         end else if (query_cond) begin
            resp_value <= operation_condition_flags;
         end else if (query_mask) begin
            resp_value <= operation_event_mask_reg;
         end
      end
   end

   // ====================================================================
   // Summary into the status byte
   // The summary is rebuilt from the registers every cycle, so it drops right after a read.
   // Only bit 7 belongs to this block; the other status byte bits are driven as zero.
   always_comb begin
      summary_bit = |(operation_event_flags_reg & operation_event_mask_reg);
      status_byte_part = 8'h00;
      status_byte_part[`OPSTAT_SUMMARY_BIT] = summary_bit;
   end

   // ====================================================================
   // Checks
   // The properties watch the registers themselves as well as the answers, so a wrong
   // answer and a wrong stored state are told apart.
   // Some one-cycle steps of a behaviour are named sequences of their own; the others are written inline.
   sequence s_done_seen;
      meas_done && !query_event;
   endsequence

   // Completions of the other two activities, each a one-cycle pulse.
   sequence s_sweep_seen;
      sweep_done;
   endsequence

   sequence s_corr_seen;
      corr_done;
   endsequence

   // An event read with no completion in the same cycle.
   sequence s_quiet_read;
      query_event && !meas_done && !sweep_done && !corr_done;
   endsequence

   // A cycle in which nothing may touch the event register.
   sequence s_idle_gap;
      !query_event && !meas_done && !sweep_done && !corr_done;
   endsequence

   // Each completion latches into its own bit.
   a_event_latch: assert property (@(posedge ref_clk) disable iff (srst)
      s_done_seen |=> operation_event_flags_reg[`OPSTAT_MEAS_BIT])
      else $error("measurement completion not latched");
   a_event_sweep: assert property (@(posedge ref_clk) disable iff (srst)
      s_sweep_seen |=> operation_event_flags_reg[`OPSTAT_SWEEP_BIT])
      else $error("list sweep completion not latched");
   a_event_corr: assert property (@(posedge ref_clk) disable iff (srst)
      s_corr_seen |=> operation_event_flags_reg[`OPSTAT_CORR_BIT])
      else $error("correction completion not latched");

   // A read returns the old contents and empties the register; bits leave only by a read.
   a_event_clear: assert property (@(posedge ref_clk) disable iff (srst)
      query_event && !meas_done && !sweep_done && !corr_done
      |=> resp_value == $past(operation_event_flags_reg)
          && operation_event_flags_reg == 16'h0000)
      else $error("event read did not return then clear");
   a_double_read: assert property (@(posedge ref_clk) disable iff (srst)
      s_quiet_read ##1 s_idle_gap ##1 s_quiet_read |=> resp_value == 16'h0000)
      else $error("second event read not empty");
   a_event_hold: assert property (@(posedge ref_clk) disable iff (srst)
      !query_event |=> (operation_event_flags_reg & $past(operation_event_flags_reg))
                        == $past(operation_event_flags_reg))
      else $error("event bit dropped without read");
   a_set_wins: assert property (@(posedge ref_clk) disable iff (srst)
      query_event && meas_done |=> operation_event_flags_reg[`OPSTAT_MEAS_BIT])
      else $error("completion lost under a read");

   // Unused bit weights never show in any register or answer.
   a_reserved_zero: assert property (@(posedge ref_clk) disable iff (srst)
      ((operation_event_flags_reg | operation_event_mask_reg | resp_value
        | operation_condition_flags) & ~`OPSTAT_LIVE_MASK) == 16'h0000)
      else $error("reserved bit set");

   // Condition reads answer the live levels of the query cycle and change nothing.
   a_cond_read: assert property (@(posedge ref_clk) disable iff (srst)
      query_cond && !query_event |=> resp_valid
         && resp_value[`OPSTAT_MEAS_BIT] == $past(meas_active)
         && resp_value[`OPSTAT_SWEEP_BIT] == $past(sweep_active)
         && resp_value[`OPSTAT_CORR_BIT] == $past(corr_active))
      else $error("condition read wrong");
   a_cond_no_side: assert property (@(posedge ref_clk) disable iff (srst)
      query_cond && !query_event && !meas_done && !sweep_done && !corr_done
      |=> operation_event_flags_reg == $past(operation_event_flags_reg))
      else $error("condition read changed events");

   // The mask takes the written weights and holds them until the next write.
   a_mask_store: assert property (@(posedge ref_clk) disable iff (srst)
      mask_write && mask_value == 16'h0010 |=> operation_event_mask_reg == 16'h0010)
      else $error("mask 16 not bit 4");
   a_mask_bits: assert property (@(posedge ref_clk) disable iff (srst)
      mask_write
      |=> operation_event_mask_reg[`OPSTAT_MEAS_BIT] == $past(mask_value[`OPSTAT_MEAS_BIT])
          && operation_event_mask_reg[`OPSTAT_SWEEP_BIT] == $past(mask_value[`OPSTAT_SWEEP_BIT])
          && operation_event_mask_reg[`OPSTAT_CORR_BIT] == $past(mask_value[`OPSTAT_CORR_BIT]))
      else $error("mask bit weights not stored");
   a_mask_hold: assert property (@(posedge ref_clk) disable iff (srst)
      !mask_write |=> operation_event_mask_reg == $past(operation_event_mask_reg))
      else $error("mask changed without a write");
   a_mask_read: assert property (@(posedge ref_clk) disable iff (srst)
      query_mask && !query_event && !query_cond && !mask_write
      |=> resp_value == $past(operation_event_mask_reg))
      else $error("mask read wrong");
   a_mask_no_side: assert property (@(posedge ref_clk) disable iff (srst)
      query_mask && !query_event && !mask_write && !meas_done && !sweep_done && !corr_done
      |=> operation_event_flags_reg == $past(operation_event_flags_reg))
      else $error("mask read changed events");

   // Every query is answered exactly one cycle later, and the answer then stands.
   a_resp_pulse: assert property (@(posedge ref_clk) disable iff (srst)
      query_event || query_cond || query_mask |=> resp_valid)
      else $error("query not answered");
   a_resp_quiet: assert property (@(posedge ref_clk) disable iff (srst)
      !query_event && !query_cond && !query_mask |=> !resp_valid
         && resp_value == $past(resp_value))
      else $error("answer without a query");

   // The summary sits in bit 7 and the rest of this byte part stays zero.
   a_summary_bit: assert property (@(posedge ref_clk) disable iff (srst)
      status_byte_part[7] == |(operation_event_flags_reg & operation_event_mask_reg)
      && status_byte_part[6:0] == 7'h00)
      else $error("summary bit wrong");
endmodule

// ### opstat_host_model.sv
// Remote controller model that issues status queries and mask writes.
`timescale 1ns/1ps
module opstat_host_model (
   input  wire logic                        ref_clk,
   input  wire logic                        resp_valid,
   input  wire opstat_pkg::opstat_word_type resp_value,
   output opstat_pkg::opstat_word_type      mask_value,
   output logic                             query_event,
   output logic                             query_cond,
   output logic                             query_mask,
   output logic                             mask_write
);
   import opstat_pkg::*;
   // ==========================================
   // Requests stand for one edge; the answer is awaited a bounded time.
   initial {query_event, query_cond, query_mask, mask_write, mask_value} = '0;
   task automatic access(input opstat_sel_type s, input logic wr, input opstat_word_type d,
                         output opstat_word_type v, output bit ok);
      @(negedge ref_clk);
      query_event = !wr && s == OPSTAT_SEL_EVENT;
      query_cond = !wr && s == OPSTAT_SEL_COND;
      query_mask = !wr && s == OPSTAT_SEL_MASK;
      mask_write = wr;
      mask_value = d;
      @(negedge ref_clk);
      {query_event, query_cond, query_mask, mask_write} = '0;
      mask_value = ~d; // A released bus no longer shows the old mask.
      ok = wr;
      v = '0;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (resp_valid === 1'h1) begin
            v = resp_value;
            ok = 1;
         end else @(negedge ref_clk);
      end
   endtask
endmodule

// ### operation_status_reporting_bench.sv
// Self-checking bench for the operation status registers.
`timescale 1ns/1ps
module operation_status_reporting_bench;
   import opstat_pkg::*;
   // ==========================================
   logic ref_clk = 1'h0, srst = 1'h1, rv, qe, qc, qm, mw, summ;
   logic [2:0] act = '0, done = '0; // Order: measure, sweep, correction.
   logic [7:0] stb;
   opstat_word_type mv, rval, v;
   bit ok;
   int failures = 0, checks_done = 0;
   localparam opstat_word_type W[3] = '{16'h0001, 16'h0008, 16'h0010};
   // Free-running clock at 8 ns.
   initial forever #4 ref_clk = ~ref_clk;
   opstat_core i_dut (.ref_clk(ref_clk), .srst(srst), .meas_active(act[2]),
      .sweep_active(act[1]), .corr_active(act[0]), .meas_done(done[2]),
      .sweep_done(done[1]), .corr_done(done[0]), .query_event(qe), .query_cond(qc),
      .query_mask(qm), .mask_write(mw), .mask_value(mv), .resp_valid(rv),
      .resp_value(rval), .summary_bit(summ), .status_byte_part(stb));
   opstat_host_model i_host (.ref_clk(ref_clk), .resp_valid(rv), .resp_value(rval),
      .mask_value(mv), .query_event(qe), .query_cond(qc), .query_mask(qm), .mask_write(mw));
   task automatic chk(input string what, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // A missing answer counts as a mismatch and ends the run.
   task automatic rd(input opstat_sel_type s, input opstat_word_type exp, input string what);
      i_host.access(s, 1'h0, '0, v, ok);
      if (!ok) begin
         failures++;
         finish_test();
      end
      chk(what, v, exp);
   endtask
   task automatic wr(input opstat_word_type d);
      i_host.access(OPSTAT_SEL_MASK, 1'h1, d, v, ok);
   endtask
   task automatic pulse(input logic [2:0] m);
      @(negedge ref_clk) done = m;
      @(negedge ref_clk) done = '0;
   endtask
   // Main sequence; reset is held for five cycles.
   initial begin
      repeat (5) @(negedge ref_clk);
      srst = 0;
      rd(OPSTAT_SEL_EVENT, 16'h0000, "event");
      rd(OPSTAT_SEL_COND, 16'h0000, "cond");
      rd(OPSTAT_SEL_MASK, 16'h0000, "mask");
      wr(16'h0010);
      rd(OPSTAT_SEL_MASK, 16'h0010, "mask");
      wr(16'hFFFF);
      rd(OPSTAT_SEL_MASK, 16'h0019, "mask");
      $display("reset and mask test done");
      for (int i = 0; i < 3; i++) begin
         act = 3'h1 << i;
         rd(OPSTAT_SEL_COND, W[i], "cond");
         rd(OPSTAT_SEL_COND, W[i], "cond again");
         pulse(3'h1 << i);
         rd(OPSTAT_SEL_EVENT, W[i], "event");
         rd(OPSTAT_SEL_EVENT, 16'h0000, "event cleared");
         rd(OPSTAT_SEL_COND, W[i], "cond after event read");
      end
      act = 3'h7;
      rd(OPSTAT_SEL_COND, 16'h0019, "cond sum");
      act = '0;
      $display("condition and event test done");
      wr(16'h0010);
      pulse(3'h3);
      chk("status byte", {8'h00, stb}, 16'h0000);
      pulse(3'h4);
      chk("status byte", {8'h00, stb}, 16'h0080);
      chk("summary", {15'h0000, summ}, 16'h0001);
      rd(OPSTAT_SEL_EVENT, 16'h0019, "event sticky");
      chk("summary after read", {15'h0000, summ}, 16'h0000);
      // A completion in the very cycle of a read must outlive that read.
      fork
         pulse(3'h4);
         rd(OPSTAT_SEL_EVENT, 16'h0000, "event in read cycle");
      join
      rd(OPSTAT_SEL_EVENT, 16'h0010, "event survives read");
      $display("summary test done");
      finish_test();
   end
endmodule
